// file: logic/hbrd_pkg.sv
// Summary of operation
// - Open-drain async ready stretches access until done
// - Async ready release edge timed by crystal clock
// - VL mode: sync ready idles high, falls at completion
// - Sync ready changes only on local clock rising edges, or at once when sync is disabled
// - EISA reads wait for ready return sampled high
// - Local select when qualifier low and address matches base
// - Local select is combinational from unlatched pins
// - Data path select grants access regardless of decode
// - Data path bursts move 32 bits per access
// - Interrupt output high for enabled pending events
// - Old interrupt select bits reserved, read zero
// - VL select low picks VL mode, else EISA
// - Byte enables ignored during data path bursts
package hbrd_pkg;

  localparam int          APB_AW            = 8;
  localparam logic [7:0]  ADDR_BASE         = 8'h00;
  localparam logic [7:0]  ADDR_CONFIG       = 8'h04;
  localparam logic [7:0]  ADDR_STATUS       = 8'h08;
  localparam logic [7:0]  ADDR_CLEAR        = 8'h0c;
  localparam logic [7:0]  ADDR_ENABLE       = 8'h10;
  localparam logic [7:0]  ADDR_STATE        = 8'h14;

  localparam logic [11:0] BASE_RESET        = 12'h030;
  localparam int          CFG_SYNC_EN_BIT   = 2;
  localparam int          CFG_ASYNC_EN_BIT  = 3;
  localparam logic [3:0]  CONFIG_RESET      = 4'hc;
  localparam logic [3:0]  CONFIG_WMASK      = 4'hc;

  localparam int          EV_ASYNC_DONE     = 0;
  localparam int          EV_SYNC_DONE      = 1;
  localparam int          EV_BURST_WORD     = 2;
  localparam int          EV_STATUS         = 3;
  localparam int          EV_W              = 4;
  localparam logic [3:0]  EV_RESET          = 4'h0;

  localparam int          CLK_PERIOD_NS     = 40;
  localparam int          ASYNC_HOLD_NS     = 120;
  localparam int          ASYNC_HOLD_CYC_I  = (ASYNC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  ASYNC_HOLD_CYC    = 4'(ASYNC_HOLD_CYC_I < 1 ? 1 : ASYNC_HOLD_CYC_I);
  localparam logic [2:0]  SYNC_WAIT_EDGES   = 3'h2;

  localparam int          CTRL_W            = 10;
  localparam logic [9:0]  CTRL_SYNC_RESET   = 10'h1ff;
  localparam int          DATA_W            = 48;
  localparam logic [47:0] DATA_SYNC_RESET   = 48'h0;

  typedef enum logic [3:0] {
    HBRD_S_IDLE  = 4'h1,
    HBRD_S_WAIT  = 4'h2,
    HBRD_S_READY = 4'h4,
    HBRD_S_RET   = 4'h8
  } hbrd_sync_state_t;

  typedef enum logic [2:0] {
    HBRD_A_IDLE = 3'h1,
    HBRD_A_HOLD = 3'h2,
    HBRD_A_DONE = 3'h4
  } hbrd_async_state_t;

endpackage

// file: logic/hbrd_sync.sv
`timescale 1ns/1ns
`default_nettype none
module hbrd_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      stage1 <= RESET_VALUE;
      o_sync <= RESET_VALUE;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule
`default_nettype wire

// file: logic/hbrd_top.sv
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
module hbrd_top
  import hbrd_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [APB_AW-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // Host pins
  input  wire logic              i_local_bus_clock,
  input  wire logic              i_address_latch_strobe_n,
  input  wire logic              i_burst_cycle_n,
  input  wire logic              i_write_not_read,
  input  wire logic              i_ready_return_n,
  input  wire logic              i_read_strobe_n,
  input  wire logic              i_write_strobe_n,
  input  wire logic              i_data_path_select_n,
  input  wire logic              i_vl_bus_mode_select_n,
  input  wire logic              i_address_qualifier,
  input  wire logic [3:0]        i_byte_enables_n,
  input  wire logic [11:0]       i_upper_address_lines,
  input  wire logic [31:0]       i_host_data,
  output logic      [31:0]       o_host_data,
  output logic                   o_host_data_oe,
  input  wire logic              i_async_access_ready,
  output logic                   o_async_access_ready,
  output logic                   o_async_access_ready_oe,
  output logic                   o_sync_ready_n,
  output logic                   o_local_device_select_n,
  output logic                   o_host_interrupt_out,
  // Internal transfer port
  input  wire logic              i_status_event,
  input  wire logic [31:0]       i_xfer_rdata,
  output logic                   o_xfer_rd,
  output logic                   o_xfer_wr,
  output logic                   o_xfer_data_path,
  output logic      [3:0]        o_xfer_be,
  output logic      [31:0]       o_xfer_wdata
);

  function automatic logic addr_hit(input logic aq, input logic [11:0] addr,
                                    input logic [11:0] base);
    addr_hit = !aq && (addr == base);
  endfunction

  logic [11:0]       base;
  logic [3:0]        config_bits;
  logic [EV_W-1:0]   status;
  logic [EV_W-1:0]   enable;
  logic [CTRL_W-1:0] ctrl_s;
  logic [DATA_W-1:0] data_s;
  logic              local_bus_clock_s;
  logic              local_bus_clock_d;
  logic              ads_n_s;
  logic              cycle_n_s;
  logic              wnr_s;
  logic              rdyrtn_n_s;
  logic              rd_n_s;
  logic              wr_n_s;
  logic              dp_n_s;
  logic              vl_n_s;
  logic              aq_s;
  logic [3:0]        be_n_s;
  logic [11:0]       addr_s;
  logic [31:0]       hdata_s;
  logic              local_bus_clock_rise;
  logic              local_bus_clock_fall;
  logic              latched_hit;
  logic              strobe_d;
  logic              strobe_fall;
  logic              async_sel;
  logic              sync_sel;
  hbrd_sync_state_t  s_state;
  hbrd_async_state_t a_state;
  logic [2:0]        s_count;
  logic [3:0]        a_count;
  logic              s_write;
  logic              a_write;
  logic              a_dp;
  logic              next_s_rd;
  logic              next_s_wr;
  logic              next_a_rd;
  logic              next_a_wr;
  logic              sync_done;
  logic              burst_word;
  logic              async_done;
  logic [EV_W-1:0]   events;
  logic              apb_setup;
  logic              apb_wr;
  logic              mapped;
  logic [31:0]       rd_value;

  hbrd_sync #(
    .WIDTH       (CTRL_W),
    .RESET_VALUE (CTRL_SYNC_RESET)
  ) u_ctrl_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   ({i_local_bus_clock, i_address_latch_strobe_n, i_burst_cycle_n,
                 i_write_not_read, i_ready_return_n, i_read_strobe_n,
                 i_write_strobe_n, i_data_path_select_n, i_vl_bus_mode_select_n,
                 i_address_qualifier}),
    .o_sync    (ctrl_s)
  );

  hbrd_sync #(
    .WIDTH       (DATA_W),
    .RESET_VALUE (DATA_SYNC_RESET)
  ) u_data_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   ({i_byte_enables_n, i_upper_address_lines, i_host_data}),
    .o_sync    (data_s)
  );

  assign {local_bus_clock_s, ads_n_s, cycle_n_s, wnr_s, rdyrtn_n_s, rd_n_s,
          wr_n_s, dp_n_s, vl_n_s, aq_s} = ctrl_s;
  assign {be_n_s, addr_s, hdata_s} = data_s;

  // Pin decode straight from the unlatched address and qualifier
  assign o_local_device_select_n =
    !addr_hit(i_address_qualifier, i_upper_address_lines, base);

  assign local_bus_clock_rise   = local_bus_clock_s && !local_bus_clock_d;
  assign local_bus_clock_fall   = !local_bus_clock_s && local_bus_clock_d;
  assign strobe_fall = strobe_d && !(rd_n_s && wr_n_s);
  assign async_sel   = latched_hit || !dp_n_s;
  assign sync_sel    = addr_hit(aq_s, addr_s, base) || !dp_n_s;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      local_bus_clock_d   <= 1'b0;
      strobe_d <= 1'b1;
    end else begin
      local_bus_clock_d   <= local_bus_clock_s;
      strobe_d <= rd_n_s && wr_n_s;
    end
  end

  // Address latch: transparent while the strobe is low, held after its rise
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      latched_hit <= 1'b0;
    end else if (!ads_n_s) begin
      latched_hit <= addr_hit(aq_s, addr_s, base);
    end
  end

  // Synchronous interface, stepped on sampled local clock edges, forced idle at once when sync is disabled
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      s_state        <= HBRD_S_IDLE;
      s_count        <= 3'h0;
      s_write        <= 1'b0;
      o_sync_ready_n <= 1'b1;
    end else if (!config_bits[CFG_SYNC_EN_BIT]) begin
      s_state        <= HBRD_S_IDLE;
      o_sync_ready_n <= 1'b1;
    end else begin
      unique case (s_state)
        HBRD_S_IDLE: begin
          if (local_bus_clock_rise && !vl_n_s && !ads_n_s && sync_sel) begin
            s_state <= HBRD_S_WAIT;
            s_count <= SYNC_WAIT_EDGES;
            s_write <= wnr_s;
          end else if (local_bus_clock_rise && vl_n_s && !cycle_n_s && !dp_n_s) begin
            s_write <= wnr_s;
            if (!wnr_s) begin
              s_state <= HBRD_S_RET;
            end
          end
        end
        HBRD_S_WAIT: begin
          if (local_bus_clock_rise) begin
            if (s_count == 3'h1) begin
              s_state        <= HBRD_S_READY;
              o_sync_ready_n <= 1'b0;
            end else begin
              s_count <= s_count - 3'h1;
            end
          end
        end
        HBRD_S_READY: begin
          if (local_bus_clock_rise) begin
            s_state        <= HBRD_S_IDLE;
            o_sync_ready_n <= 1'b1;
          end
        end
        HBRD_S_RET: begin
          if (local_bus_clock_fall && rdyrtn_n_s) begin
            s_state <= HBRD_S_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    next_s_rd  = 1'b0;
    next_s_wr  = 1'b0;
    burst_word = 1'b0;
    sync_done  = 1'b0;
    if (config_bits[CFG_SYNC_EN_BIT]) begin
      if (s_state == HBRD_S_WAIT && local_bus_clock_rise && s_count == 3'h1) begin
        next_s_rd = !s_write;
        next_s_wr = s_write;
        sync_done = 1'b1;
      end
      if (s_state == HBRD_S_IDLE && local_bus_clock_rise && vl_n_s && !cycle_n_s && !dp_n_s) begin
        next_s_rd  = !wnr_s;
        next_s_wr  = wnr_s;
        burst_word = wnr_s;
      end
      if (s_state == HBRD_S_RET && local_bus_clock_fall && rdyrtn_n_s) begin
        burst_word = 1'b1;
      end
    end
  end

  // Asynchronous interface: pull ready low, release after a crystal-clock count
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      a_state                 <= HBRD_A_IDLE;
      a_count                 <= 4'h0;
      a_write                 <= 1'b0;
      a_dp                    <= 1'b0;
      o_async_access_ready_oe <= 1'b0;
    end else begin
      unique case (a_state)
        HBRD_A_IDLE: begin
          if (strobe_fall && async_sel && config_bits[CFG_ASYNC_EN_BIT]) begin
            a_state                 <= HBRD_A_HOLD;
            a_count                 <= ASYNC_HOLD_CYC;
            a_write                 <= !wr_n_s;
            a_dp                    <= !dp_n_s;
            o_async_access_ready_oe <= 1'b1;
          end
        end
        HBRD_A_HOLD: begin
          if (a_count == 4'h1) begin
            a_state                 <= HBRD_A_DONE;
            o_async_access_ready_oe <= 1'b0;
          end else begin
            a_count <= a_count - 4'h1;
          end
        end
        HBRD_A_DONE: begin
          if (rd_n_s && wr_n_s) begin
            a_state <= HBRD_A_IDLE;
          end
        end
      endcase
    end
  end

  assign o_async_access_ready = 1'b0;
  assign async_done = (a_state == HBRD_A_HOLD) && (a_count == 4'h1);
  assign next_a_rd  = async_done && !a_write;
  assign next_a_wr  = async_done && a_write;

  // Transfer port toward the packet path and register file
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_xfer_rd        <= 1'b0;
      o_xfer_wr        <= 1'b0;
      o_xfer_data_path <= 1'b0;
      o_xfer_be        <= 4'h0;
      o_xfer_wdata     <= 32'h0;
    end else begin
      o_xfer_rd <= next_s_rd || (next_a_rd && !next_s_wr);
      o_xfer_wr <= next_s_wr || (next_a_wr && !next_s_rd);
      if (next_s_rd || next_s_wr || next_a_rd || next_a_wr) begin
        o_xfer_data_path <= !dp_n_s;
        o_xfer_be        <= dp_n_s ? ~be_n_s : 4'hf;
        o_xfer_wdata     <= hdata_s;
      end
    end
  end

  // Host data bus: driven during selected reads
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_host_data    <= 32'h0;
      o_host_data_oe <= 1'b0;
    end else begin
      if (o_xfer_rd) begin
        o_host_data <= i_xfer_rdata;
      end
      o_host_data_oe <= (a_state != HBRD_A_IDLE && !a_write && !rd_n_s)
                        || (s_state == HBRD_S_RET)
                        || (s_state != HBRD_S_IDLE && !s_write && vl_n_s == 1'b0);
    end
  end

  // Interrupt status, set wins over clear
  assign events[EV_ASYNC_DONE] = async_done;
  assign events[EV_SYNC_DONE]  = sync_done;
  assign events[EV_BURST_WORD] = burst_word;
  assign events[EV_STATUS]     = i_status_event;

  assign apb_setup = i_psel && !i_penable;
  assign apb_wr    = i_psel && i_penable && i_pwrite;
  assign mapped    = (i_paddr == ADDR_BASE) || (i_paddr == ADDR_CONFIG)
                     || (i_paddr == ADDR_STATUS) || (i_paddr == ADDR_CLEAR)
                     || (i_paddr == ADDR_ENABLE) || (i_paddr == ADDR_STATE);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      status <= EV_RESET;
    end else if (apb_wr && i_paddr == ADDR_CLEAR) begin
      status <= (status & ~i_pwdata[EV_W-1:0]) | events;
    end else begin
      status <= status | events;
    end
  end

  assign o_host_interrupt_out = |(status & enable);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      base        <= BASE_RESET;
      config_bits <= CONFIG_RESET;
      enable      <= EV_RESET;
    end else if (apb_wr) begin
      if (i_paddr == ADDR_BASE) begin
        base <= i_pwdata[11:0];
      end
      if (i_paddr == ADDR_CONFIG) begin
        config_bits <= i_pwdata[3:0] & CONFIG_WMASK;
      end
      if (i_paddr == ADDR_ENABLE) begin
        enable <= i_pwdata[EV_W-1:0];
      end
    end
  end

  always_comb begin
    rd_value = 32'h0;
    if (i_paddr == ADDR_BASE) begin
      rd_value[11:0] = base;
    end else if (i_paddr == ADDR_CONFIG) begin
      rd_value[3:0] = config_bits;
    end else if (i_paddr == ADDR_STATUS) begin
      rd_value[EV_W-1:0] = status;
    end else if (i_paddr == ADDR_ENABLE) begin
      rd_value[EV_W-1:0] = enable;
    end else if (i_paddr == ADDR_STATE) begin
      rd_value[3:0]  = s_state;
      rd_value[6:4]  = a_state;
      rd_value[8]    = !vl_n_s;
      rd_value[9]    = local_bus_clock_s;
      rd_value[10]   = latched_hit;
      rd_value[11]   = o_host_interrupt_out;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_prdata  <= 32'h0;
      o_pslverr <= 1'b0;
    end else if (apb_setup) begin
      o_prdata  <= i_pwrite ? 32'h0 : rd_value;
      o_pslverr <= !mapped;
    end
  end

  assign o_pready = i_psel && i_penable;

endmodule
`default_nettype wire

// file: dv/hbrd_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module hbrd_monitor
  import hbrd_pkg::*;
(
  input wire logic              i_clk,
  input wire logic              i_reset_n,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [APB_AW-1:0] i_paddr,
  input wire logic [31:0]       i_pwdata,
  input wire logic              i_local_bus_clock,
  input wire logic              i_vl_bus_mode_select_n,
  input wire logic              i_address_qualifier,
  input wire logic [11:0]       i_upper_address_lines,
  input wire logic              i_status_event,
  input wire logic              o_async_access_ready,
  input wire logic              o_async_access_ready_oe,
  input wire logic              o_sync_ready_n,
  input wire logic              o_local_device_select_n,
  input wire logic              o_host_interrupt_out,
  input wire logic              o_xfer_rd,
  input wire logic              o_xfer_wr,
  input wire logic              o_xfer_data_path,
  input wire logic [3:0]        o_xfer_be
);
  logic        apb_wr;
  logic [11:0] base;
  logic [3:0]  enable;
  logic [5:0]  local_bus_clock_hist;
  logic        local_bus_clock_rose;
  assign apb_wr    = i_psel && i_penable && i_pwrite;
  assign local_bus_clock_rose = |(local_bus_clock_hist[4:0] & ~local_bus_clock_hist[5:1]);
  // Shadow copies of decode base and interrupt enables
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      base   <= BASE_RESET;
      enable <= EV_RESET;
    end else if (apb_wr && i_paddr == ADDR_BASE) begin
      base <= i_pwdata[11:0];
    end else if (apb_wr && i_paddr == ADDR_ENABLE) begin
      enable <= i_pwdata[3:0];
    end
  end
  // Recent samples of the bus clock
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      local_bus_clock_hist <= 6'h00;
    end else begin
      local_bus_clock_hist <= {local_bus_clock_hist[4:0], i_local_bus_clock};
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence async_access_ready_held;
    o_async_access_ready_oe [*3] ##1 !o_async_access_ready_oe;
  endsequence
  sequence srdy_low;
    !o_sync_ready_n [*6] ##[1:4] o_sync_ready_n;
  endsequence
  decode_match_a: assert property (o_local_device_select_n ==
    !(!i_address_qualifier && i_upper_address_lines == base)) else $error("decode wrong");
  decode_off_a: assert property (i_address_qualifier |-> o_local_device_select_n)
    else $error("select while qualifier high");
  async_access_ready_hold_a: assert property ($rose(o_async_access_ready_oe) |-> async_access_ready_held)
    else $error("ready stretch length wrong");
  async_access_ready_drain_a: assert property (o_async_access_ready == 1'b0)
    else $error("ready pin driven high");
  srdy_pulse_a: assert property ($fell(o_sync_ready_n) |-> srdy_low)
    else $error("sync ready pulse wrong");
  srdy_clock_a: assert property ($changed(o_sync_ready_n) |-> local_bus_clock_rose)
    else $error("sync ready off bus clock");
  srdy_eisa_a: assert property (i_vl_bus_mode_select_n [*4] |-> o_sync_ready_n)
    else $error("sync ready active in burst mode");
  irq_set_a: assert property (i_status_event && enable[EV_STATUS] && !apb_wr
    |=> o_host_interrupt_out) else $error("interrupt missing");
  irq_off_a: assert property (enable == 4'h0 |-> !o_host_interrupt_out)
    else $error("interrupt while disabled");
  burst_width_a: assert property ((o_xfer_rd || o_xfer_wr) && o_xfer_data_path
    |-> o_xfer_be == 4'hf) else $error("burst not full word");
endmodule
bind hbrd_top hbrd_monitor i_mon (.*);
`default_nettype wire

// file: dv/hbrd_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module hbrd_host_model (
  input  wire logic i_clk,
  input  wire logic i_run,
  input  wire logic i_ret_hold,
  input  wire logic i_async_access_ready_oe,
  output logic      o_local_bus_clock,
  output logic      o_ready_return_n,
  output logic      o_async_access_ready_wire,
  output logic      o_async_access_ready_seen
);
  logic [1:0] async_access_ready_sync;
  // Bus clock at 3.125 MHz, still while idle
  initial begin
    o_local_bus_clock = 1'b0;
    #7;
    forever begin
      #160;
      o_local_bus_clock = i_run ? ~o_local_bus_clock : 1'b0;
    end
  end
  // Ready return moves on rising edges, settled at falling edges
  initial o_ready_return_n = 1'b1;
  always @(posedge o_local_bus_clock) o_ready_return_n <= !i_ret_hold;
  // Open-drain ready with pull-up, resynchronised before use
  assign o_async_access_ready_wire = !i_async_access_ready_oe;
  always @(posedge i_clk) async_access_ready_sync <= {async_access_ready_sync[0], o_async_access_ready_wire};
  assign o_async_access_ready_seen = async_access_ready_sync[1];
endmodule
`default_nettype wire

// file: dv/hbrd_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module hbrd_top_test
  import hbrd_pkg::*;
;
  logic              i_clk, i_reset_n, i_psel, i_penable, i_pwrite, i_status_event;
  logic [APB_AW-1:0] i_paddr;
  logic [31:0]       i_pwdata, i_xfer_rdata, o_prdata, o_host_data, o_xfer_wdata, wd, d;
  logic [31:0]       hval;
  wire logic [31:0]  i_host_data;
  logic              i_address_latch_strobe_n, i_burst_cycle_n, i_write_not_read;
  logic              i_read_strobe_n, i_write_strobe_n, i_data_path_select_n;
  logic              i_vl_bus_mode_select_n, i_address_qualifier, run, ret_hold, hdrv, e, dp;
  logic [3:0]        i_byte_enables_n, o_xfer_be, be;
  logic [11:0]       i_upper_address_lines;
  logic              o_pready, o_pslverr, o_host_data_oe, o_async_access_ready;
  logic              o_async_access_ready_oe, o_sync_ready_n, o_local_device_select_n;
  logic              o_host_interrupt_out, o_xfer_rd, o_xfer_wr, o_xfer_data_path;
  wire logic         i_local_bus_clock, i_ready_return_n, i_async_access_ready;
  int                n_errors, checks, n_rd, n_wr, h, n;
  assign i_host_data = o_host_data_oe ? o_host_data : (hdrv ? hval : 32'hffffffff);
  always #20 i_clk = ~i_clk;
  hbrd_top i_dut (.*);
  hbrd_host_model i_host (.i_clk(i_clk), .i_run(run), .i_ret_hold(ret_hold),
    .i_async_access_ready_oe(o_async_access_ready_oe), .o_local_bus_clock(i_local_bus_clock),
    .o_ready_return_n(i_ready_return_n), .o_async_access_ready_wire(i_async_access_ready), .o_async_access_ready_seen());
  always @(negedge i_clk) begin
    if (o_xfer_wr === 1'b1) begin
      n_wr++;
      wd = o_xfer_wdata;
    end
    if (o_xfer_rd === 1'b1) n_rd++;
    if (o_xfer_rd === 1'b1 || o_xfer_wr === 1'b1) begin
      be = o_xfer_be;
      dp = o_xfer_data_path;
    end
  end
  task end_sim;
    if (n_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task chk_w(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask
  task chk_b(input string nm, input logic x, input logic g);
    chk_w(nm, {31'h0, x}, {31'h0, g});
  endtask
  task apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_psel   <= 1'b1;
    i_pwrite <= w;
    i_paddr  <= a;
    i_pwdata <= v;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1) @(posedge i_clk);
    d = o_prdata;
    e = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task dec(input logic q, input logic [11:0] a, input logic x);
    @(posedge i_clk);
    i_address_qualifier   <= q;
    i_upper_address_lines <= a;
    @(negedge i_clk);
    chk_b("local select", x, o_local_device_select_n);
  endtask
  task async_acc(input logic w);
    n = 0;
    h = 0;
    @(posedge i_clk);
    hdrv <= w;
    if (w) i_write_strobe_n <= 1'b0;
    else i_read_strobe_n <= 1'b0;
    while (i_async_access_ready !== 1'b0 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    while (i_async_access_ready === 1'b0 && h < 20) begin
      @(negedge i_clk);
      h++;
    end
    repeat (4) @(negedge i_clk);
  endtask
  task strobes_off;
    @(posedge i_clk);
    i_read_strobe_n  <= 1'b1;
    i_write_strobe_n <= 1'b1;
    hdrv             <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
  initial begin
    #400000;
    n_errors++;
    end_sim();
  end
  initial begin
    {i_clk, i_reset_n, i_psel, i_penable, i_pwrite, i_status_event, run, ret_hold, hdrv} = '0;
    {i_address_latch_strobe_n, i_burst_cycle_n, i_read_strobe_n, i_write_strobe_n} = '1;
    {i_data_path_select_n, i_vl_bus_mode_select_n, i_address_qualifier} = '1;
    {i_write_not_read, i_paddr, i_pwdata, i_upper_address_lines, hval} = '0;
    {n_errors, checks, n_rd, n_wr} = '0;
    i_byte_enables_n = 4'hf;
    i_xfer_rdata     = 32'h13572468;
    repeat (10) @(posedge i_clk);
    i_reset_n <= 1'b1;
    dec(1'b0, BASE_RESET, 1'b0);
    dec(1'b1, BASE_RESET, 1'b1);
    dec(1'b0, BASE_RESET ^ 12'h800, 1'b1);
    apb(1'b1, ADDR_BASE, 32'h000005a5);
    dec(1'b0, 12'h5a5, 1'b0);
    dec(1'b0, 12'h5a4, 1'b1);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk_w("config reset", 32'(CONFIG_RESET), d);
    apb(1'b1, ADDR_CONFIG, 32'hf);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk_w("config bits", 32'(CONFIG_WMASK), d);
    apb(1'b0, 8'h40, 32'h0);
    chk_b("unmapped error", 1'b1, e);
    dec(1'b0, 12'h5a5, 1'b0);
    @(posedge i_clk);
    i_address_latch_strobe_n <= 1'b0;
    i_byte_enables_n         <= 4'ha;
    hval                     <= 32'hc0ffee11;
    @(posedge i_clk);
    i_address_latch_strobe_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    async_acc(1'b1);
    chk_w("ready hold", 32'(ASYNC_HOLD_CYC), h);
    chk_w("write data", 32'hc0ffee11, wd);
    chk_w("byte enables", 32'h5, {28'h0, be});
    strobes_off();
    dec(1'b1, 12'h000, 1'b1);
    @(posedge i_clk);
    i_data_path_select_n <= 1'b0;
    i_byte_enables_n     <= 4'he;
    async_acc(1'b0);
    chk_w("ready hold", 32'(ASYNC_HOLD_CYC), h);
    chk_w("read data", i_xfer_rdata, i_host_data);
    chk_w("burst enables", 32'hf, {28'h0, be});
    chk_b("data path", 1'b1, dp);
    strobes_off();
    i_data_path_select_n <= 1'b1;
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk_b("async done", 1'b1, d[EV_ASYNC_DONE]);
    apb(1'b1, ADDR_CLEAR, 32'hf);
    apb(1'b1, ADDR_ENABLE, 32'h8);
    @(negedge i_clk);
    chk_b("irq idle", 1'b0, o_host_interrupt_out);
    @(posedge i_clk);
    i_status_event <= 1'b1;
    @(posedge i_clk);
    i_status_event <= 1'b0;
    @(negedge i_clk);
    chk_b("irq set", 1'b1, o_host_interrupt_out);
    apb(1'b1, ADDR_ENABLE, 32'h0);
    @(negedge i_clk);
    chk_b("irq masked", 1'b0, o_host_interrupt_out);
    apb(1'b1, ADDR_ENABLE, 32'h8);
    @(negedge i_clk);
    chk_b("irq unmasked", 1'b1, o_host_interrupt_out);
    apb(1'b1, ADDR_CLEAR, 32'h8);
    @(negedge i_clk);
    chk_b("irq cleared", 1'b0, o_host_interrupt_out);
    @(posedge i_clk);
    i_vl_bus_mode_select_n   <= 1'b0;
    i_address_qualifier      <= 1'b0;
    i_upper_address_lines    <= 12'h5a5;
    i_write_not_read         <= 1'b1;
    hval                     <= 32'h0badcafe;
    hdrv                     <= 1'b1;
    i_address_latch_strobe_n <= 1'b0;
    run                      <= 1'b1;
    @(posedge i_local_bus_clock);
    repeat (3) @(posedge i_clk);
    i_address_latch_strobe_n <= 1'b1;
    n = 0;
    while (o_sync_ready_n !== 1'b0 && n < 200) begin
      @(negedge i_clk);
      n++;
    end
    chk_b("sync ready fall", 1'b0, o_sync_ready_n);
    repeat (20) @(negedge i_clk);
    chk_b("sync ready idle", 1'b1, o_sync_ready_n);
    chk_w("sync write data", 32'h0badcafe, wd);
    @(posedge i_clk);
    i_write_not_read         <= 1'b0;
    hdrv                     <= 1'b0;
    i_address_latch_strobe_n <= 1'b0;
    @(posedge i_local_bus_clock);
    repeat (3) @(posedge i_clk);
    i_address_latch_strobe_n <= 1'b1;
    h = n_rd;
    repeat (12) @(negedge i_clk);
    chk_b("sync read drive", 1'b1, o_host_data_oe);
    repeat (20) @(negedge i_clk);
    chk_w("sync reads", h + 1, n_rd);
    @(posedge i_clk);
    run                    <= 1'b0;
    hdrv                   <= 1'b0;
    i_vl_bus_mode_select_n <= 1'b1;
    i_write_not_read       <= 1'b0;
    ret_hold               <= 1'b1;
    i_data_path_select_n   <= 1'b0;
    i_burst_cycle_n        <= 1'b0;
    repeat (20) @(posedge i_clk);
    h   = n_rd;
    run <= 1'b1;
    @(posedge i_local_bus_clock);
    repeat (3) @(posedge i_clk);
    i_burst_cycle_n <= 1'b1;
    repeat (40) @(negedge i_clk);
    chk_w("burst reads", h + 1, n_rd);
    chk_b("burst data drive", 1'b1, o_host_data_oe);
    chk_w("burst data", i_xfer_rdata, i_host_data);
    ret_hold <= 1'b0;
    repeat (40) @(negedge i_clk);
    chk_b("burst end", 1'b0, o_host_data_oe);
    @(posedge i_clk);
    i_write_not_read <= 1'b1;
    hval             <= 32'h600dbeef;
    hdrv             <= 1'b1;
    i_burst_cycle_n  <= 1'b0;
    h = n_wr;
    @(posedge i_local_bus_clock);
    repeat (3) @(posedge i_clk);
    i_burst_cycle_n <= 1'b1;
    repeat (8) @(negedge i_clk);
    chk_w("burst writes", h + 1, n_wr);
    chk_w("burst write data", 32'h600dbeef, wd);
    run <= 1'b0;
    end_sim();
  end
endmodule
`default_nettype wire
